// file: hdl/reset_and_strap_mode_control.sv
// reset sequencer: reset pin synchronising, reset stretch, bus release,
// software reset-out pulse and reset-latched special modes
// assumes core-side requests are on clk_i; pins are synchronised here
// Operation
// - external reset goes through two flops before use
// - memory inhibit stays asserted throughout reset
// - internal reset stretched 128 clocks after synchronised reset negates
// - in reset, bus outputs float and other outputs sit inactive
// - after release bus stays floating until grant, then reset fetch begins
// - straps sampled at reset negation select modes held until next reset
// - busy and in-progress, and transfer ack, driven negated before floating at reset
// - reset ends a bus cycle as if acknowledged, restarts exception flow
// - software reset drives reset-out 512 clocks, internal state untouched
// - external reset during reset-out resets at once and negates reset-out
// - three drive-strength groups chosen from priority lines during reset
// - cache-disable strap low selects multiplexed address/data mode
// - multiplexed: address drives in first clock only, data from second
// - translation-disable strap low selects strobe-latched read mode
// - read latch passes while strobe negated, holds while asserted
// - a clocked register captures the latch output every edge
// - mode off: latch always transparent, edge capture only
// - strobe asserted keeps data held internally while data lines move
// - selected modes stay in force until next reset
`include "rsc_map.svh"
module reset_and_strap_mode_control
    import rsc_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   clk_en_i,
    input  wire logic                   external_reset_in_n_i,
    input  wire logic                   bus_grant_n_i,
    input  wire logic                   cache_disable_strap_i,
    input  wire logic                   translation_disable_strap_i,
    input  wire logic [`RSC_IPL_W-1:0]  priority_level_inputs_i,
    input  wire logic [`RSC_DATA_W-1:0] data_lines_i,
    input  wire logic                   data_latch_strobe_n_i,
    input  wire logic                   soft_reset_req_i,
    input  wire logic                   cycle_start_i,
    input  wire logic                   cycle_write_i,
    input  wire logic                   cycle_done_i,
    input  wire logic                   bus_busy_req_i,
    input  wire logic                   transfer_in_progress_req_i,
    input  wire logic                   transfer_ack_req_i,
    output logic                        internal_reset_o,
    output logic                        memory_inhibit_n_o,
    output logic                        reset_out_pin_n_o,
    output logic                        bus_busy_n_o,
    output logic                        bus_busy_oe_o,
    output logic                        transfer_in_progress_n_o,
    output logic                        transfer_in_progress_oe_o,
    output logic                        transfer_ack_n_o,
    output logic                        transfer_ack_oe_o,
    output logic                        address_oe_o,
    output logic                        data_oe_o,
    output logic                        cycle_terminate_o,
    output logic                        reset_fetch_start_o,
    output logic                        mux_bus_mode_o,
    output logic                        dle_mode_o,
    output logic [`RSC_IPL_W-1:0]       drive_large_o,
    output logic [`RSC_DATA_W-1:0]      read_data_o
);
    logic [`RSC_PIN_W-1:0]      pin_s1_q;
    logic [`RSC_PIN_W-1:0]      pin_s2_q;
    logic                       ext_rst_seen;
    logic                       grant_seen;
    rst_state_e                 state_q;
    rst_state_e                 state_d;
    logic [`RSC_STRETCH_W-1:0]  stretch_cnt_q;
    logic [`RSC_RESET_OUT_PIN_W-1:0]     reset_out_pin_cnt_q;
    logic                       reset_out_pin_n_q;
    logic                       int_rst_q;
    logic                       mi_n_q;
    logic                       strap_take;
    logic                       leave_run;
    logic                       mux_q;
    logic                       dle_q;
    logic [`RSC_IPL_W-1:0]      large_q;
    logic [`RSC_CTL_W-1:0]      ctl_req;
    logic [`RSC_CTL_W-1:0]      ctl_oe_q;
    logic [`RSC_CTL_W-1:0]      ctl_n_q;
    cyc_phase_e                 phase_q;
    cyc_phase_e                 phase_d;
    logic                       write_q;
    logic                       addr_oe_q;
    logic                       data_oe_q;
    logic                       term_q;
    logic                       fetch_q;
    read_latch_if               rl ();

    // two-flop synchroniser on reset and straps
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pin_s1_q <= `RSC_PIN_RST_VAL;
            pin_s2_q <= `RSC_PIN_RST_VAL;
        end else if (clk_en_i) begin
            pin_s1_q <= {external_reset_in_n_i, bus_grant_n_i, cache_disable_strap_i,
                         translation_disable_strap_i, priority_level_inputs_i};
            pin_s2_q <= pin_s1_q;
        end
    end

    assign ext_rst_seen = !pin_s2_q[`RSC_PIN_EXT];
    assign grant_seen   = !pin_s2_q[`RSC_PIN_GNT];
    assign strap_take   = (state_q == RST_HOLD) && !ext_rst_seen;
    assign leave_run    = (state_q == RST_RUN) && ext_rst_seen;
    assign ctl_req      = {bus_busy_req_i, transfer_in_progress_req_i, transfer_ack_req_i};

    // reset sequence; recognised external reset wins over every other state
    always_comb begin
        state_d = state_q;
        case (state_q)
            RST_HOLD: begin
                if (!ext_rst_seen) begin
                    state_d = RST_STRETCH;
                end
            end
            RST_STRETCH: begin
                if (ext_rst_seen) begin
                    state_d = RST_HOLD;
                end else if (stretch_cnt_q == `RSC_STRETCH_LAST) begin
                    state_d = RST_WAIT_GRANT;
                end
            end
            RST_WAIT_GRANT: begin
                if (ext_rst_seen) begin
                    state_d = RST_HOLD;
                end else if (grant_seen) begin
                    state_d = RST_RUN;
                end
            end
            RST_RUN: begin
                if (ext_rst_seen) begin
                    state_d = RST_HOLD;
                end
            end
            default: state_d = RST_HOLD;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_q <= RST_HOLD;
        end else if (clk_en_i) begin
            state_q <= state_d;
        end
    end

    // stretch count, 128 clocks in the stretch state
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            stretch_cnt_q <= '0;
        end else if (clk_en_i) begin
            if (ext_rst_seen || state_q != RST_STRETCH) begin
                stretch_cnt_q <= '0;
            end else begin
                stretch_cnt_q <= stretch_cnt_q + 1'b1;
            end
        end
    end

    // internal reset covers hold and stretch
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            int_rst_q <= 1'b1;
        end else if (clk_en_i) begin
            int_rst_q <= (state_d == RST_HOLD) || (state_d == RST_STRETCH);
        end
    end

    // memory inhibit asserted in reset and until the first cycle
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mi_n_q <= 1'b0;
        end else if (clk_en_i) begin
            if (state_d != RST_RUN) begin
                mi_n_q <= 1'b0;
            end else if (cycle_start_i) begin
                mi_n_q <= 1'b1;
            end
        end
    end

    // 512-clock reset-out pulse, leaves modes untouched
    // external reset cancels the pulse at once
    // pulse count restarts on recognised reset
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            reset_out_pin_n_q   <= 1'b1;
            reset_out_pin_cnt_q <= '0;
        end else if (clk_en_i) begin
            if (ext_rst_seen) begin
                reset_out_pin_n_q   <= 1'b1;
                reset_out_pin_cnt_q <= '0;
            end else if (reset_out_pin_n_q) begin
                reset_out_pin_cnt_q <= '0;
                if (soft_reset_req_i && state_q == RST_RUN) begin
                    reset_out_pin_n_q <= 1'b0;
                end
            end else if (reset_out_pin_cnt_q == `RSC_RESET_OUT_PIN_LAST) begin
                reset_out_pin_n_q <= 1'b1;
            end else begin
                reset_out_pin_cnt_q <= reset_out_pin_cnt_q + 1'b1;
            end
        end
    end

    // straps caught on the clock reset negation is seen
    // one strength bit per driver group
    // no other path writes the mode flops
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mux_q   <= 1'b0;
            dle_q   <= 1'b0;
            large_q <= `RSC_STRENGTH_RST;
        end else if (clk_en_i && strap_take) begin
            mux_q   <= !pin_s2_q[`RSC_PIN_CACHE_DISABLE_STRAP];
            dle_q   <= !pin_s2_q[`RSC_PIN_TRANSLATION_DISABLE_STRAP];
            large_q <= pin_s2_q[`RSC_IPL_W-1:0];
        end
    end

    // on reset, driven control lines go one clock negated before floating
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctl_oe_q <= '0;
            ctl_n_q  <= '1;
        end else if (clk_en_i) begin
            if (state_d == RST_RUN) begin
                ctl_oe_q <= ctl_req;
                ctl_n_q  <= ~ctl_req;
            end else if (leave_run) begin
                ctl_oe_q <= ctl_oe_q;
                ctl_n_q  <= '1;
            end else begin
                ctl_oe_q <= '0;
                ctl_n_q  <= '1;
            end
        end
    end

    // bus cycle phases; a reset drops the cycle wherever it stands
    always_comb begin
        phase_d = phase_q;
        case (phase_q)
            PH_IDLE: begin
                if (cycle_start_i) begin
                    phase_d = PH_C1;
                end
            end
            PH_C1:   phase_d = PH_C2;
            PH_C2: begin
                phase_d = cycle_done_i ? PH_IDLE : PH_DATA;
            end
            PH_DATA: begin
                if (cycle_done_i) begin
                    phase_d = PH_IDLE;
                end
            end
            default: phase_d = PH_IDLE;
        endcase
        if (state_d != RST_RUN) begin
            phase_d = PH_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            phase_q <= PH_IDLE;
            write_q <= 1'b0;
        end else if (clk_en_i) begin
            phase_q <= phase_d;
            if (phase_q == PH_IDLE && cycle_start_i) begin
                write_q <= cycle_write_i;
            end
        end
    end

    // multiplexed: address only in the first clock, data from the second
    // nothing driven until the grant moves the sequence to run
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            addr_oe_q <= 1'b0;
            data_oe_q <= 1'b0;
        end else if (clk_en_i) begin
            addr_oe_q <= (phase_d == PH_C1) || (!mux_q && phase_d != PH_IDLE);
            data_oe_q <= write_q && (phase_d == PH_C2 || phase_d == PH_DATA);
        end
    end

    // reset ends an open cycle as if acknowledged
    // first cycle after grant is the reset fetch
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            term_q  <= 1'b0;
            fetch_q <= 1'b0;
        end else if (clk_en_i) begin
            term_q  <= leave_run && phase_q != PH_IDLE;
            fetch_q <= state_q == RST_WAIT_GRANT && state_d == RST_RUN;
        end
    end

    assign rl.data_pin     = data_lines_i;
    assign rl.strobe_n_pin = data_latch_strobe_n_i;
    assign rl.dle_mode     = dle_q;

    read_data_latch u_rdl (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .clk_en_i (clk_en_i),
        .lp       (rl)
    );

    // outputs, all straight from flops
    assign internal_reset_o          = int_rst_q;
    assign memory_inhibit_n_o        = mi_n_q;
    assign reset_out_pin_n_o         = reset_out_pin_n_q;
    assign bus_busy_oe_o             = ctl_oe_q[2];
    assign bus_busy_n_o              = ctl_n_q[2];
    assign transfer_in_progress_oe_o = ctl_oe_q[1];
    assign transfer_in_progress_n_o  = ctl_n_q[1];
    assign transfer_ack_oe_o         = ctl_oe_q[0];
    assign transfer_ack_n_o          = ctl_n_q[0];
    assign address_oe_o              = addr_oe_q;
    assign data_oe_o                 = data_oe_q;
    assign cycle_terminate_o         = term_q;
    assign reset_fetch_start_o       = fetch_q;
    assign mux_bus_mode_o            = mux_q;
    assign dle_mode_o                = dle_q;
    assign drive_large_o             = large_q;
    assign read_data_o               = rl.read_data;

    AST_SYNC_LAG: assert property (@(posedge clk_i) disable iff (!rst_n_i || !clk_en_i)
        $past(rst_n_i) && $past(rst_n_i, 2) && $past(clk_en_i) && $past(clk_en_i, 2) |->
        pin_s2_q[`RSC_PIN_EXT] == $past(external_reset_in_n_i, 2))
        else $error("reset pin not seen two clocks later");

    AST_MI_RESET: assert property (@(posedge clk_i) disable iff (!rst_n_i || !clk_en_i)
        int_rst_q |-> !mi_n_q)
        else $error("memory inhibit negated in reset");

    AST_STRETCH_LEN: assert property (@(posedge clk_i) disable iff (!rst_n_i || !clk_en_i)
        $fell(int_rst_q) |-> $past(stretch_cnt_q) == `RSC_STRETCH_LAST)
        else $error("internal reset released early");

    AST_FLOAT_RESET: assert property (@(posedge clk_i) disable iff (!rst_n_i || !clk_en_i)
        int_rst_q && $past(int_rst_q) |-> ctl_oe_q == '0 && !addr_oe_q && !data_oe_q)
        else $error("bus driven during reset");

    AST_WAIT_GRANT: assert property (@(posedge clk_i) disable iff (!rst_n_i || !clk_en_i)
        state_q == RST_WAIT_GRANT |-> !addr_oe_q && !data_oe_q && ctl_oe_q == '0)
        else $error("bus driven before grant");

    AST_NEGATE_FIRST: assert property (@(posedge clk_i) disable iff (!rst_n_i || !clk_en_i)
        leave_run && ctl_oe_q[2] |=> bus_busy_oe_o && bus_busy_n_o ##1 !bus_busy_oe_o)
        else $error("busy not negated before floating");

    AST_RESET_OUT_PIN_LEN: assert property (@(posedge clk_i) disable iff (!rst_n_i || !clk_en_i)
        $rose(reset_out_pin_n_q) |-> $past(reset_out_pin_cnt_q) == `RSC_RESET_OUT_PIN_LAST || $past(ext_rst_seen))
        else $error("reset-out pulse wrong length");

    AST_RESET_OUT_PIN_KILL: assert property (@(posedge clk_i) disable iff (!rst_n_i || !clk_en_i)
        ext_rst_seen |=> reset_out_pin_n_q && int_rst_q)
        else $error("reset-out not cancelled by external reset");

    AST_MODE_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i || !clk_en_i)
        !$past(strap_take) |-> $stable(mux_q) && $stable(dle_q) && $stable(large_q))
        else $error("mode changed outside reset");

    AST_MUX_ADDR: assert property (@(posedge clk_i) disable iff (!rst_n_i || !clk_en_i)
        mux_q && phase_q == PH_C1 && state_d == RST_RUN |=> !addr_oe_q)
        else $error("address still driven in second clock");
endmodule : reset_and_strap_mode_control

// file: hdl/rsc_map.svh
// constants for the reset sequencer and reset-latched mode selection
// assumes inclusion by bare name from the package and the design modules
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH

`define RSC_STRETCH_CYCLES 128
`define RSC_STRETCH_W      7
`define RSC_STRETCH_LAST   7'h7f
`define RSC_RESET_OUT_PIN_CYCLES    512
`define RSC_RESET_OUT_PIN_W         9
`define RSC_RESET_OUT_PIN_LAST      9'h1ff
`define RSC_PIN_W          7
`define RSC_PIN_EXT        6
`define RSC_PIN_GNT        5
`define RSC_PIN_CACHE_DISABLE_STRAP       4
`define RSC_PIN_TRANSLATION_DISABLE_STRAP       3
`define RSC_IPL_W          3
`define RSC_DATA_W         32
`define RSC_CTL_W          3
// reset pin bit starts asserted, so a freshly reset block cannot leave hold on stale ones
`define RSC_PIN_RST_VAL    7'h3f
`define RSC_STRENGTH_RST   3'h0
`define RSC_DATA_RST       32'h0000_0000

`endif

// file: hdl/rsc_pkg.sv
// types shared by the reset sequencer modules
// assumes rsc_map.svh is on the include path
`include "rsc_map.svh"
package rsc_pkg;
    typedef enum logic [1:0] {
        RST_HOLD,
        RST_STRETCH,
        RST_WAIT_GRANT,
        RST_RUN
    } rst_state_e;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_C1,
        PH_C2,
        PH_DATA
    } cyc_phase_e;
endpackage : rsc_pkg

// file: hdl/read_latch_if.sv
// carrier between the sequencer and its read data latch
// assumes both ends run on the same bus clock
`include "rsc_map.svh"
interface read_latch_if;
    logic [`RSC_DATA_W-1:0] data_pin;
    logic                   strobe_n_pin;
    logic                   dle_mode;
    logic [`RSC_DATA_W-1:0] read_data;

    modport latch (
        input  data_pin,
        input  strobe_n_pin,
        input  dle_mode,
        output read_data
    );
    modport owner (
        output data_pin,
        output strobe_n_pin,
        output dle_mode,
        input  read_data
    );
endinterface : read_latch_if

// file: hdl/read_data_latch.sv
// read path: strobe-held latch stage followed by a clocked capture stage
// assumes data and strobe come straight from pins, so both are synchronised here
`include "rsc_map.svh"
module read_data_latch
    import rsc_pkg::*;
(
    input  wire logic  clk_i,
    input  wire logic  rst_n_i,
    input  wire logic  clk_en_i,
    read_latch_if.latch lp
);
    logic [`RSC_DATA_W-1:0] data_s1_q;
    logic [`RSC_DATA_W-1:0] data_s2_q;
    logic                   strb_s1_q;
    logic                   strb_s2_q;
    logic [`RSC_DATA_W-1:0] hold_q;
    logic [`RSC_DATA_W-1:0] read_q;
    logic                   holding;
    logic [`RSC_DATA_W-1:0] stage_a;

    // pin synchronisers, first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            data_s1_q <= `RSC_DATA_RST;
            data_s2_q <= `RSC_DATA_RST;
            strb_s1_q <= 1'b1;
            strb_s2_q <= 1'b1;
        end else if (clk_en_i) begin
            data_s1_q <= lp.data_pin;
            data_s2_q <= data_s1_q;
            strb_s1_q <= lp.strobe_n_pin;
            strb_s2_q <= strb_s1_q;
        end
    end

    assign holding = lp.dle_mode && !strb_s2_q;
    assign stage_a = holding ? hold_q : data_s2_q;

    // flop-based stand-in for the level latch, avoids a real latch in the flow
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            hold_q <= `RSC_DATA_RST;
        end else if (clk_en_i) begin
            hold_q <= stage_a;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            read_q <= `RSC_DATA_RST;
        end else if (clk_en_i) begin
            read_q <= stage_a;
        end
    end

    assign lp.read_data = read_q;

    AST_DLE_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i || !clk_en_i)
        holding && $past(holding) |-> read_q == $past(read_q))
        else $error("read data changed while strobe held");

    AST_TRANSPARENT: assert property (@(posedge clk_i) disable iff (!rst_n_i || !clk_en_i)
        !$past(lp.dle_mode) |-> read_q == $past(data_s2_q))
        else $error("read data not following bus with mode off");
endmodule : read_data_latch

// file: test/reset_bus_partner.sv
// model of the external reset circuit, strap drivers and bus arbiter
// assumes the bench raises reset_req_i and picks reset-time strap levels
module reset_bus_partner (
    input  wire logic       clk_i,
    input  wire logic       reset_req_i,
    input  wire logic       internal_reset_i,
    input  wire logic [4:0] reset_straps_i,  // {cache, translation, priority[2:0]}
    output logic            external_reset_in_n_o,
    output logic            bus_grant_n_o,
    output logic [4:0]      straps_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] low_cnt_q;
    logic [5:0] high_cnt_q;
    logic [2:0] gnt_cnt_q;

    // pins start in reset with straps at their reset-time levels
    initial begin
        external_reset_in_n_o = 1'b0;
        bus_grant_n_o = 1'b1;
        straps_o = reset_straps_i;
        low_cnt_q = 4'h0;
        high_cnt_q = 6'h00;
        gnt_cnt_q = 3'h0;
    end

    // reset pin held low ten clocks or more
    always @(posedge clk_i) begin
        external_reset_in_n_o <= !(reset_req_i || (!external_reset_in_n_o && low_cnt_q < 4'ha));
        low_cnt_q <= external_reset_in_n_o ? 4'h0 : low_cnt_q + {3'h0, low_cnt_q != 4'hf};
    end

    // straps back to normal levels long before the stretch ends
    always @(posedge clk_i) begin
        high_cnt_q <= !external_reset_in_n_o ? 6'h00 : high_cnt_q + {5'h0, high_cnt_q != 6'h3f};
        straps_o <= (!external_reset_in_n_o || high_cnt_q < 6'h10) ? reset_straps_i : 5'h1f;
    end

    // grant comes late on purpose, so a floating bus can be seen meanwhile
    always @(posedge clk_i) begin
        gnt_cnt_q <= (internal_reset_i !== 1'b0) ? 3'h0 : gnt_cnt_q + {2'h0, gnt_cnt_q != 3'h7};
        bus_grant_n_o <= (gnt_cnt_q != 3'h7);
    end
endmodule : reset_bus_partner

// file: test/testbench.sv
// bench: reset stretch, straps, mux cycle, read latch, reset-out pulse
// assumes the partner model owns reset pin, grant and strap pins
`include "rsc_map.svh"
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i, rst_n_i, clk_en_i, external_reset_in_n_i, bus_grant_n_i, reset_req;
    logic cache_disable_strap_i, translation_disable_strap_i, data_latch_strobe_n_i;
    logic soft_reset_req_i, cycle_start_i, cycle_write_i, cycle_done_i;
    logic bus_busy_req_i, transfer_in_progress_req_i, transfer_ack_req_i;
    logic [2:0] priority_level_inputs_i, drive_large_o;
    logic [31:0] data_lines_i, read_data_o;
    logic internal_reset_o, memory_inhibit_n_o, reset_out_pin_n_o, bus_busy_n_o;
    logic bus_busy_oe_o, transfer_in_progress_n_o, transfer_in_progress_oe_o;
    logic transfer_ack_n_o, transfer_ack_oe_o, address_oe_o, data_oe_o;
    logic cycle_terminate_o, reset_fetch_start_o, mux_bus_mode_o, dle_mode_o;
    logic seen, prev_oe, prev_n, neg_ok;
    logic [4:0] rst_straps;
    int n_mismatch, n_compared, cnt, at;

    reset_and_strap_mode_control u_reset_and_strap_mode_control (.*);
    reset_bus_partner u_reset_bus_partner (.clk_i(clk_i), .reset_req_i(reset_req),
        .internal_reset_i(internal_reset_o), .reset_straps_i(rst_straps),
        .external_reset_in_n_o(external_reset_in_n_i), .bus_grant_n_o(bus_grant_n_i),
        .straps_o({cache_disable_strap_i, translation_disable_strap_i,
                   priority_level_inputs_i}));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic end_sim;
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    // release the reset pin and time the internal reset, then await grant
    task automatic release_run();
        reset_req = 1'b0;
        for (cnt = 0; internal_reset_o !== 1'b0 && cnt < 400; cnt++) step(1);
        check(cnt >= 130 && cnt <= 137, 1, "stretch length");
        if (cnt >= 400) end_sim();
        for (at = 0; reset_fetch_start_o !== 1'b1 && at < 40; at++) begin
            check(address_oe_o | bus_busy_oe_o | data_oe_o, 0, "bus floats");
            step(1);
        end
        check(at > 3 && at < 40, 1, "fetch after grant");
        if (at >= 40) end_sim();
        step(1);
    endtask : release_run

    // strobe low holds read data only in strobe-latched mode
    task automatic rd(input logic held);
        data_lines_i = 32'ha5a5_0001;
        data_latch_strobe_n_i = 1'b1;
        step(4);
        check(read_data_o, 32'ha5a5_0001, "latch pass");
        data_latch_strobe_n_i = 1'b0;
        step(4);
        data_lines_i = 32'h5a5a_0002;
        step(4);
        check(read_data_o, held ? 32'ha5a5_0001 : 32'h5a5a_0002, "latch hold");
        data_latch_strobe_n_i = 1'b1;
        step(4);
        check(read_data_o, 32'h5a5a_0002, "latch reopen");
    endtask : rd

    initial begin
        {rst_n_i, soft_reset_req_i, cycle_start_i, cycle_write_i, cycle_done_i} = 5'h00;
        {bus_busy_req_i, transfer_in_progress_req_i, transfer_ack_req_i} = 3'h0;
        {clk_en_i, reset_req, data_latch_strobe_n_i} = 3'h7;
        data_lines_i = 32'h0000_0000;
        rst_straps = 5'h05;
        step(8);
        rst_n_i = 1'b1;
        step(4);
        check(memory_inhibit_n_o, 0, "inhibit in reset");
        check({bus_busy_oe_o, transfer_in_progress_oe_o, transfer_ack_oe_o}, 0, "float");
        check({bus_busy_n_o, transfer_in_progress_n_o, transfer_ack_n_o, reset_out_pin_n_o},
              15, "inactive levels");
        release_run();
        check({mux_bus_mode_o, dle_mode_o, drive_large_o}, 5'h1d, "modes");
        // mux write: address one clock, then data
        cycle_start_i = 1'b1;
        cycle_write_i = 1'b1;
        step(1);
        cycle_start_i = 1'b0;
        check(address_oe_o, 1, "address first clock");
        check(memory_inhibit_n_o, 1, "inhibit off at first cycle");
        step(1);
        check({address_oe_o, data_oe_o}, 1, "data second clock");
        cycle_done_i = 1'b1;
        step(1);
        cycle_done_i = 1'b0;
        rd(1'b1);
        soft_reset_req_i = 1'b1;
        step(1);
        soft_reset_req_i = 1'b0;
        cnt = 0;
        repeat (600) begin
            cnt += (reset_out_pin_n_o === 1'b0);
            step(1);
        end
        check(cnt, 512, "reset-out length");
        check({internal_reset_o, mux_bus_mode_o}, 1, "state kept");
        // open cycle with busy driven, reset-out running, then pin reset
        {bus_busy_req_i, transfer_in_progress_req_i} = 2'h3;
        cycle_start_i = 1'b1;
        cycle_write_i = 1'b0;
        soft_reset_req_i = 1'b1;
        step(1);
        {cycle_start_i, soft_reset_req_i} = 2'h0;
        step(10);
        check({bus_busy_oe_o, bus_busy_n_o, transfer_in_progress_oe_o, transfer_in_progress_n_o,
               reset_out_pin_n_o}, 5'h14, "busy driven");
        {reset_req, seen, neg_ok, at} = {3'h4, 32'h0};
        rst_straps = 5'h1a;
        for (int i = 1; i < 12; i++) begin
            {prev_oe, prev_n} = {bus_busy_oe_o, bus_busy_n_o};
            step(1);
            seen |= cycle_terminate_o;
            if (at == 0 && reset_out_pin_n_o === 1'b1) at = i;
            if (prev_oe === 1'b1 && bus_busy_oe_o === 1'b0) neg_ok = prev_n;
        end
        check(at >= 2 && at <= 5, 1, "reset-out cut");
        check({seen, neg_ok, bus_busy_oe_o}, 6, "cycle ended, busy negated");
        check(memory_inhibit_n_o, 0, "inhibit again");
        check({transfer_in_progress_oe_o, transfer_in_progress_n_o}, 1, "in-progress floated");
        {bus_busy_req_i, transfer_in_progress_req_i} = 2'h0;
        release_run();
        check({mux_bus_mode_o, dle_mode_o, drive_large_o}, 5'h02, "new modes");
        // plain bus: address held past the first clock, no data on a read
        cycle_start_i = 1'b1;
        step(1);
        cycle_start_i = 1'b0;
        step(1);
        check({address_oe_o, data_oe_o}, 2, "address held");
        cycle_done_i = 1'b1;
        step(1);
        cycle_done_i = 1'b0;
        check(address_oe_o, 0, "address off after done");
        rd(1'b0);
        end_sim();
    end
endmodule : testbench
